// *** core/slot_power_map.svh ***
`ifndef SLOT_POWER_MAP_SVH
`define SLOT_POWER_MAP_SVH
// What this block does
// - Main rails switch on at enable rising edge, off at enable falling edge.
// - Main enable low after a fault clears the slot's main fault latch.
// - Aux output switches on at aux enable rising edge, off at its falling edge.
// - Aux enable low after a fault clears the slot's aux fault latch.
// - Trip alert pin of a slot pulls low whenever its breaker trips.
// - Alert from a main rail fault releases when main enable goes low.
// - Alert from an aux fault releases when aux enable goes low.
// - With main and aux both faulted, alert holds until both enables low.
// - Breaker trips only after current limit lasts the full breaker delay.
// - Both general inputs are reported at common status bits four and five.
// - Bus base address comes from two address-select inputs, open reads high.
// - Interrupt pin pulls low on a power fault unless the mask bit is set.
// - Interrupt releases after software echo-resets the fault bits, or once the common mask bit or the fault mask bits are set.
// - Overtemperature or undervoltage drops the slot gate at once; overcurrent drops it only after the breaker delay.

// ********************************
// Sizes
// ********************************
`define SLOTS 2
`define REG_AW 4
`define REG_DW 8
`define TMR_W 16
`define EV_W 5
`define SYNC_W 19

// ********************************
// Register offsets
// ********************************
`define OFF_STAT_A 4'h0
`define OFF_STAT_B 4'h1
`define OFF_COMMON 4'h2
`define OFF_CTRL 4'h3
`define OFF_MASK_A 4'h4
`define OFF_MASK_B 4'h5
`define OFF_ADDR 4'h6

// ********************************
// Field positions
// ********************************
`define ST_MAIN_FLT 0
`define ST_AUX_FLT 1
`define ST_MAIN_ON 2
`define ST_AUX_ON 3
`define ST_ALERT 4
`define ST_OC 5
`define ST_UV 6
`define ST_OT 7
`define ST_STICKY 8'hE3
`define CS_ADDR_LO 0
`define CS_ADDR_HI 1
`define CS_MASK_BIT 3
`define CS_GENERAL_LO 4
`define CS_IRQ_PIN 6
`define EV_MAIN 0
`define EV_AUX 1
`define EV_OC 2
`define EV_UV 3
`define EV_OT 4

// ********************************
// Reset values and timing
// ********************************
`define RST_STAT 8'h00
`define RST_MASK 8'h00
`define RST_IRQ_MASK 1'b0
`define RST_BASE 7'h00
`define RD_IDLE 8'h00
`define SMB_ADDR_PREFIX 5'h0A
`define CLK_MHZ 25
`define BREAKER_DELAY_US 1000
`define BREAKER_DELAY_CYC (`BREAKER_DELAY_US * `CLK_MHZ)

`endif

// *** core/slot_power_pkg.sv ***
package slot_power_pkg;
`include "slot_power_map.svh"

    typedef logic [`REG_AW-1:0] reg_addr_t;
    typedef logic [`REG_DW-1:0] reg_data_t;
    typedef logic [`TMR_W-1:0] tmr_t;
    typedef logic [`EV_W-1:0] ev_t;
    typedef logic [`SLOTS-1:0] slot_t;

    // State of one slot's power and fault logic
    typedef struct packed {
        logic main_on;
        logic aux_on;
        logic main_lat;
        logic aux_lat;
        logic main_en_q;
        logic aux_en_q;
        tmr_t main_tmr;
        tmr_t aux_tmr;
        ev_t ev;
    } slot_state_s;

    // State of the register file and interrupt
    typedef struct packed {
        logic [`SLOTS-1:0][`REG_DW-1:0] stat;
        logic [`SLOTS-1:0][`REG_DW-1:0] mask;
        logic irq_mask;
        logic irq;
        reg_data_t rdata;
        logic [6:0] base_addr;
    } top_state_s;

endpackage

// *** core/pin_sync.sv ***
`timescale 1ns/10ps
`include "slot_power_map.svh"

module pin_sync
#(
    parameter int W = `SYNC_W
)
(
    input logic clk_sys,
    input logic sys_rst,
    input logic clk_en,
    input logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_s;

    sync_state_s q;
    sync_state_s d;

    // Two stages; only the second stage is read outside
    always_comb
    begin
        d = q;
        if (clk_en)
        begin
            d.meta = din;
            d.stable = q.meta;
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            q <= '0;
        else
            q <= d;
    end

    assign dout = q.stable;

endmodule // pin_sync

// *** core/slot_fault_latch.sv ***
`timescale 1ns/10ps
`include "slot_power_map.svh"

module slot_fault_latch
#(
    parameter int DELAY = `BREAKER_DELAY_CYC
)
(
    input logic clk_sys,
    input logic sys_rst,
    input logic clk_en,
    input logic main_en,
    input logic aux_en,
    input logic sw_main_on,
    input logic sw_main_off,
    input logic sw_aux_on,
    input logic sw_aux_off,
    input logic main_ilim,
    input logic aux_ilim,
    input logic in_uv,
    input logic over_temp,
    output logic main_gate,
    output logic aux_gate,
    output logic alert,
    output slot_power_pkg::ev_t ev
);
    import slot_power_pkg::*;

    localparam tmr_t LIM = tmr_t'(DELAY - 1);

    slot_state_s q;
    slot_state_s d;
    logic main_trip;
    logic aux_trip;
    logic main_flt;
    logic aux_flt;

    // Enable edges, breaker timers and fault latches
    always_comb
    begin
        d = q;
        main_trip = 1'b0;
        aux_trip = 1'b0;
        d.ev = '0;
        if (q.main_on && main_ilim)
        begin
            if (q.main_tmr == LIM)
                main_trip = 1'b1;
            else
                d.main_tmr = q.main_tmr + tmr_t'(1);
        end
        else
            d.main_tmr = '0;
        if (q.aux_on && aux_ilim)
        begin
            if (q.aux_tmr == LIM)
                aux_trip = 1'b1;
            else
                d.aux_tmr = q.aux_tmr + tmr_t'(1);
        end
        else
            d.aux_tmr = '0;
        main_flt = main_trip | (q.main_on & (in_uv | over_temp));
        aux_flt = aux_trip | (q.aux_on & over_temp);
        d.main_en_q = main_en;
        d.aux_en_q = aux_en;
        // main on at rise, off at fall
        if ((~main_en & q.main_en_q) | sw_main_off)
            d.main_on = 1'b0;
        else if (((main_en & ~q.main_en_q) | sw_main_on) & ~q.main_lat)
            d.main_on = 1'b1;
        // aux on at rise, off at fall
        if ((~aux_en & q.aux_en_q) | sw_aux_off)
            d.aux_on = 1'b0;
        else if (((aux_en & ~q.aux_en_q) | sw_aux_on) & ~q.aux_lat)
            d.aux_on = 1'b1;
        if (main_flt)
        begin
            d.main_on = 1'b0;
            d.main_lat = 1'b1;
        end
        else if (~main_en)
            d.main_lat = 1'b0;
        if (aux_flt)
        begin
            d.aux_on = 1'b0;
            d.aux_lat = 1'b1;
        end
        else if (~aux_en)
            d.aux_lat = 1'b0;
        d.ev[`EV_MAIN] = main_flt;
        d.ev[`EV_AUX] = aux_flt;
        d.ev[`EV_OC] = main_trip | aux_trip;
        d.ev[`EV_UV] = q.main_on & in_uv;
        d.ev[`EV_OT] = (q.main_on | q.aux_on) & over_temp;
        if (!clk_en)
            d = q;
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            q <= '0;
        else
            q <= d;
    end

    assign main_gate = q.main_on;
    assign aux_gate = q.aux_on;
    assign alert = q.main_lat | q.aux_lat;
    assign ev = q.ev;

endmodule // slot_fault_latch

// *** core/slot_power_fault_logic.sv ***
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "slot_power_map.svh"

module slot_power_fault_logic
#(
    parameter int BREAKER_DELAY_CYC = `BREAKER_DELAY_CYC
)
(
    input logic clk_sys,
    input logic sys_rst,
    input logic clk_en,
    input slot_power_pkg::reg_addr_t reg_addr,
    input slot_power_pkg::reg_data_t reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output slot_power_pkg::reg_data_t reg_rdata,
    input slot_power_pkg::slot_t main_rail_enable,
    input slot_power_pkg::slot_t aux_rail_enable,
    input slot_power_pkg::slot_t main_ilim,
    input slot_power_pkg::slot_t aux_ilim,
    input slot_power_pkg::slot_t in_undervolt,
    input slot_power_pkg::slot_t over_temp,
    input slot_power_pkg::slot_t general_input,
    input logic addr_select_hi,
    input logic addr_select_lo,
    output slot_power_pkg::slot_t main_gate,
    output slot_power_pkg::slot_t aux_output,
    input slot_power_pkg::slot_t fault_alert_i,
    output slot_power_pkg::slot_t fault_alert_o,
    output slot_power_pkg::slot_t fault_alert_oe_n,
    input logic irq_i,
    output logic irq_o,
    output logic irq_oe_n,
    output logic [6:0] smb_base_addr
);
    import slot_power_pkg::*;

    // ********************************
    // Helper functions
    // ********************************

    // Address match for one register
    function automatic logic reg_hit(input reg_addr_t a,
                                     input reg_addr_t off);
        reg_hit = (a == off);
    endfunction

    // Slot events placed at their status bit positions
    function automatic reg_data_t ev_bits(input ev_t e);
        reg_data_t v;
        v = '0;
        v[`ST_MAIN_FLT] = e[`EV_MAIN];
        v[`ST_AUX_FLT] = e[`EV_AUX];
        v[`ST_OC] = e[`EV_OC];
        v[`ST_UV] = e[`EV_UV];
        v[`ST_OT] = e[`EV_OT];
        ev_bits = v;
    endfunction

    // ********************************
    // Declarations
    // ********************************
    top_state_s q;
    top_state_s d;
    logic [`SYNC_W-1:0] pin_raw;
    logic [`SYNC_W-1:0] pin_s;
    slot_t main_en_s;
    slot_t aux_en_s;
    slot_t main_ilim_s;
    slot_t aux_ilim_s;
    slot_t uv_s;
    slot_t ot_s;
    slot_t general_s;
    slot_t alert_pin_s;
    logic addr_lo_s;
    logic addr_hi_s;
    logic irq_pin_s;
    logic wr_ctrl;
    slot_t sw_main_on;
    slot_t sw_main_off;
    slot_t sw_aux_on;
    slot_t sw_aux_off;
    slot_t alert;
    ev_t ev [`SLOTS];
    reg_data_t stat_view [`SLOTS];
    reg_data_t common_view;
    reg_data_t ctrl_view;
    reg_data_t rd_val;
    reg_data_t clr;
    logic pend;

    // ********************************
    // Pin synchronisers
    // ********************************

    // Every outside level enters through two flip-flops
    assign pin_raw = {irq_i, fault_alert_i, addr_select_hi, addr_select_lo,
                      general_input, over_temp, in_undervolt, aux_ilim,
                      main_ilim, aux_rail_enable, main_rail_enable};

    pin_sync #(
        .W(`SYNC_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .din(pin_raw),
        .dout(pin_s)
    );

    // Split the synchronised vector
    assign main_en_s = pin_s[1:0];
    assign aux_en_s = pin_s[3:2];
    assign main_ilim_s = pin_s[5:4];
    assign aux_ilim_s = pin_s[7:6];
    assign uv_s = pin_s[9:8];
    assign ot_s = pin_s[11:10];
    assign general_s = pin_s[13:12];
    assign addr_lo_s = pin_s[14];
    assign addr_hi_s = pin_s[15];
    assign alert_pin_s = pin_s[17:16];
    assign irq_pin_s = pin_s[18];

    // ********************************
    // Software power control
    // ********************************

    // A control write turns each rail on (one) or off (zero)
    assign wr_ctrl = reg_wr & reg_hit(reg_addr, `OFF_CTRL);

    // Per-slot request pulses from the control register
    always_comb
    begin
        for (int i = 0; i < `SLOTS; i++)
        begin
            sw_main_on[i] = wr_ctrl & reg_wdata[2 * i];
            sw_main_off[i] = wr_ctrl & ~reg_wdata[2 * i];
            sw_aux_on[i] = wr_ctrl & reg_wdata[2 * i + 1];
            sw_aux_off[i] = wr_ctrl & ~reg_wdata[2 * i + 1];
        end
    end

    // ********************************
    // Slot power and fault latches
    // ********************************
    genvar gi;
    generate
        for (gi = 0; gi < `SLOTS; gi++)
        begin : g_slot
            slot_fault_latch #(
                .DELAY(BREAKER_DELAY_CYC)
            ) u_slot (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .clk_en(clk_en),
                .main_en(main_en_s[gi]),
                .aux_en(aux_en_s[gi]),
                .sw_main_on(sw_main_on[gi]),
                .sw_main_off(sw_main_off[gi]),
                .sw_aux_on(sw_aux_on[gi]),
                .sw_aux_off(sw_aux_off[gi]),
                .main_ilim(main_ilim_s[gi]),
                .aux_ilim(aux_ilim_s[gi]),
                .in_uv(uv_s[gi]),
                .over_temp(ot_s[gi]),
                .main_gate(main_gate[gi]),
                .aux_gate(aux_output[gi]),
                .alert(alert[gi]),
                .ev(ev[gi])
            );
        end
    endgenerate

    // ********************************
    // Open-drain outputs
    // ********************************

    assign fault_alert_o = '0;
    assign fault_alert_oe_n = ~alert;

    // Interrupt pin pulls low while the flag is up
    assign irq_o = 1'b0;
    assign irq_oe_n = ~q.irq;

    // ********************************
    // Register read views
    // ********************************

    // Slot status: sticky faults plus live rail and pin state
    always_comb
    begin
        for (int i = 0; i < `SLOTS; i++)
        begin
            stat_view[i] = q.stat[i] & `ST_STICKY;
            stat_view[i][`ST_MAIN_ON] = main_gate[i];
            stat_view[i][`ST_AUX_ON] = aux_output[i];
            stat_view[i][`ST_ALERT] = alert_pin_s[i];
        end
    end

    // Common status and control readback
    always_comb
    begin
        common_view = '0;
        common_view[`CS_ADDR_LO] = addr_lo_s;
        common_view[`CS_ADDR_HI] = addr_hi_s;
        common_view[`CS_MASK_BIT] = q.irq_mask;
        // general inputs at bits four and five
        common_view[`CS_GENERAL_LO +: `SLOTS] = general_s;
        common_view[`CS_IRQ_PIN] = irq_pin_s;
        ctrl_view = '0;
        for (int i = 0; i < `SLOTS; i++)
        begin
            ctrl_view[2 * i] = main_gate[i];
            ctrl_view[2 * i + 1] = aux_output[i];
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb
    begin
        if (reg_hit(reg_addr, `OFF_STAT_A))
            rd_val = stat_view[0];
        else if (reg_hit(reg_addr, `OFF_STAT_B))
            rd_val = stat_view[1];
        else if (reg_hit(reg_addr, `OFF_COMMON))
            rd_val = common_view;
        else if (reg_hit(reg_addr, `OFF_CTRL))
            rd_val = ctrl_view;
        else if (reg_hit(reg_addr, `OFF_MASK_A))
            rd_val = q.mask[0];
        else if (reg_hit(reg_addr, `OFF_MASK_B))
            rd_val = q.mask[1];
        else if (reg_hit(reg_addr, `OFF_ADDR))
            rd_val = {1'b0, q.base_addr};
        else
            rd_val = `RD_IDLE;
    end

    // ********************************
    // Register file and interrupt
    // ********************************
    always_comb
    begin
        d = q;
        clr = '0;
        pend = 1'b0;
        // Read data stand only in the cycle after the strobe
        d.rdata = reg_rd ? rd_val : `RD_IDLE;
        for (int i = 0; i < `SLOTS; i++)
        begin
            if (reg_wr && reg_hit(reg_addr, i == 0 ? `OFF_STAT_A
                                                  : `OFF_STAT_B))
                clr = reg_wdata & `ST_STICKY;
            else
                clr = '0;
            // New events win over a clear in the same cycle
            d.stat[i] = (q.stat[i] & ~clr) | ev_bits(ev[i]);
            if (reg_wr && reg_hit(reg_addr, i == 0 ? `OFF_MASK_A
                                                  : `OFF_MASK_B))
                d.mask[i] = reg_wdata & `ST_STICKY;
            pend = pend | (|(q.stat[i] & ~q.mask[i] & `ST_STICKY));
        end
        if (reg_wr && reg_hit(reg_addr, `OFF_COMMON))
            d.irq_mask = reg_wdata[`CS_MASK_BIT];
        // masked by the common mask bit
        d.irq = pend & ~q.irq_mask;
        d.base_addr = {`SMB_ADDR_PREFIX, addr_hi_s, addr_lo_s};
        if (!clk_en)
            d = q;
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q.stat <= {`SLOTS{`RST_STAT}};
            q.mask <= {`SLOTS{`RST_MASK}};
            q.irq_mask <= `RST_IRQ_MASK;
            q.irq <= 1'b0;
            q.rdata <= `RD_IDLE;
            q.base_addr <= `RST_BASE;
        end
        else
            q <= d;
    end

    assign reg_rdata = q.rdata;
    assign smb_base_addr = q.base_addr;

endmodule // slot_power_fault_logic

// *** bench/slot_power_chk.sv ***
`timescale 1ns/10ps
`include "slot_power_map.svh"
module slot_power_chk
#(
    parameter int BREAKER_DELAY_CYC = 8
)
(
    input logic clk_sys,
    input logic sys_rst,
    input slot_power_pkg::reg_addr_t reg_addr,
    input slot_power_pkg::reg_data_t reg_wdata,
    input logic reg_wr,
    input slot_power_pkg::slot_t main_rail_enable,
    input slot_power_pkg::slot_t aux_rail_enable,
    input slot_power_pkg::slot_t main_ilim,
    input slot_power_pkg::slot_t in_undervolt,
    input slot_power_pkg::slot_t over_temp,
    input logic addr_select_hi,
    input logic addr_select_lo,
    input slot_power_pkg::slot_t main_gate,
    input slot_power_pkg::slot_t fault_alert_oe_n,
    input logic irq_oe_n,
    input logic [6:0] smb_base_addr
);
    import slot_power_pkg::*;
    logic cm_q;
    logic ma_q;

    // Mirror of the mask settings software has written
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cm_q <= 1'b0;
            ma_q <= 1'b0;
        end
        else if (reg_wr && reg_addr == `OFF_COMMON)
            cm_q <= reg_wdata[`CS_MASK_BIT];
        else if (reg_wr && reg_addr == `OFF_MASK_A)
            ma_q <= |reg_wdata;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    // ****************
    // Slot A pins, gates and alert
    // ****************
    AST_MAIN_ON: assert property (
        $rose(main_rail_enable[0]) && fault_alert_oe_n[0] ##1
        (main_rail_enable[0] && !in_undervolt[0] && !over_temp[0])[*3]
        |-> main_gate[0]) else $error("main gate not raised");
    AST_MAIN_OFF: assert property (
        $fell(main_rail_enable[0]) ##1 (!main_rail_enable[0])[*3]
        |-> !main_gate[0]) else $error("main gate not dropped");
    AST_ALERT_REL: assert property (
        $fell(main_rail_enable[0]) && !aux_rail_enable[0] ##1
        (!main_rail_enable[0] && !aux_rail_enable[0] && !main_ilim[0]
        && !in_undervolt[0] && !over_temp[0])[*3]
        |-> fault_alert_oe_n[0]) else $error("alert not released");
    AST_TRIP_WAIT: assert property (
        $rose(main_ilim[0]) && main_gate[0] |-> main_gate[0][*8])
        else $error("breaker tripped early");
    AST_TRIP_BOUND: assert property (
        $rose(main_ilim[0]) && main_gate[0] ##1 main_ilim[0][*8]
        |-> ##[0:6] !main_gate[0]) else $error("breaker never tripped");
    AST_TRIP_ALERT: assert property (
        $fell(main_gate[0]) && main_rail_enable[0]
        |-> !fault_alert_oe_n[0]) else $error("trip without alert");
    AST_GATE_DROP: assert property (
        (in_undervolt[0] || over_temp[0])[*4] |-> !main_gate[0])
        else $error("gate on during fault");

    // ****************
    // Interrupt and address
    // ****************
    AST_IRQ_SET: assert property (
        $fell(fault_alert_oe_n[0]) && !cm_q && !ma_q
        |-> ##[1:4] !irq_oe_n) else $error("interrupt missing");
    AST_IRQ_MASK: assert property (
        cm_q |-> ##1 irq_oe_n) else $error("masked interrupt active");
    AST_IRQ_REL: assert property (
        $rose(irq_oe_n) |-> $past(reg_wr, 2))
        else $error("interrupt released without write");
    AST_BASE: assert property (
        ($stable(addr_select_hi) && $stable(addr_select_lo))[*5]
        |-> smb_base_addr[1:0] == {addr_select_hi, addr_select_lo})
        else $error("base address wrong");
endmodule // slot_power_chk

bind slot_power_fault_logic slot_power_chk
#(.BREAKER_DELAY_CYC(BREAKER_DELAY_CYC)) slot_power_chk_i
(
    .clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .main_rail_enable, .aux_rail_enable, .main_ilim, .in_undervolt,
    .over_temp, .addr_select_hi, .addr_select_lo, .main_gate,
    .fault_alert_oe_n, .irq_oe_n, .smb_base_addr
);

// *** bench/slot_host_board.sv ***
`timescale 1ns/10ps
module slot_host_board
(
    input logic sw_ctl,
    input slot_power_pkg::slot_t main_req,
    input slot_power_pkg::slot_t aux_req,
    input slot_power_pkg::slot_t alert_o,
    input slot_power_pkg::slot_t alert_oe_n,
    input logic irq_o,
    input logic irq_oe_n,
    output slot_power_pkg::slot_t main_rail_enable,
    output slot_power_pkg::slot_t aux_rail_enable,
    output slot_power_pkg::slot_t alert_wire,
    output logic irq_wire,
    output logic addr_select_hi,
    output logic addr_select_lo
);
    import slot_power_pkg::*;
    assign main_rail_enable = sw_ctl ? 2'h0 : main_req;
    assign aux_rail_enable = sw_ctl ? 2'h0 : aux_req;
    // Pull-ups: a wire reads low only while pulled
    assign alert_wire = alert_oe_n | alert_o;
    assign irq_wire = irq_oe_n | irq_o;
    // address straps left open, pulled high
    assign addr_select_hi = 1'b1;
    assign addr_select_lo = 1'b1;
endmodule // slot_host_board

// *** bench/slot_power_fault_logic_tb_top.sv ***
`timescale 1ns/10ps
`include "slot_power_map.svh"
module slot_power_fault_logic_tb_top;
    import slot_power_pkg::*;
    localparam int DLY = 8;
    logic clk_sys;
    logic sys_rst;
    reg_addr_t reg_addr;
    reg_data_t reg_wdata;
    reg_data_t reg_rdata;
    logic reg_wr, reg_rd, sw_ctl, irq_o, irq_oe_n, irq_wire, a_hi, a_lo;
    slot_t main_req, aux_req, main_ilim, aux_ilim, in_undervolt, over_temp;
    slot_t general_input, main_en, aux_en, main_gate, aux_output;
    slot_t alert_o, alert_oe_n, alert_wire;
    logic [6:0] smb_base_addr;
    int err_total = 0;
    int num_checks = 0;

    // Clock source
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    slot_power_fault_logic #(.BREAKER_DELAY_CYC(DLY)) slot_power_fault_logic_i
    (
        .clk_sys, .sys_rst, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .main_rail_enable(main_en),
        .aux_rail_enable(aux_en), .main_ilim, .aux_ilim, .in_undervolt,
        .over_temp, .general_input, .addr_select_hi(a_hi),
        .addr_select_lo(a_lo), .main_gate, .aux_output,
        .fault_alert_i(alert_wire), .fault_alert_o(alert_o),
        .fault_alert_oe_n(alert_oe_n), .irq_i(irq_wire), .irq_o,
        .irq_oe_n, .smb_base_addr
    );

    slot_host_board slot_host_board_i
    (
        .sw_ctl, .main_req, .aux_req, .alert_o, .alert_oe_n, .irq_o,
        .irq_oe_n, .main_rail_enable(main_en), .aux_rail_enable(aux_en),
        .alert_wire, .irq_wire, .addr_select_hi(a_hi), .addr_select_lo(a_lo)
    );

    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, seen, want);
        end
    endtask

    task automatic final_report();
        if (err_total == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input reg_addr_t a, input reg_data_t d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input reg_addr_t a, input reg_data_t want);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, want);
    endtask

    // Bounded wait for the slot A breaker to open
    task automatic wait_trip();
        int n;
        n = 0;
        while (main_gate[0] !== 1'b0 && n < 40)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 40)
        begin
            err_total++;
            final_report();
        end
        #1;
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic s_regs();
        rd(`OFF_STAT_A, 8'h10);
        rd(`OFF_COMMON, 8'h63);
        chk({1'b0, smb_base_addr}, {1'b0, `SMB_ADDR_PREFIX, 2'h3});
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00);
        wr(`OFF_MASK_B, 8'hE3);
        rd(`OFF_MASK_B, 8'hE3);
        wr(`OFF_MASK_B, 8'h00);
    endtask

    task automatic s_pins();
        @(posedge clk_sys);
        main_req <= 2'h1;
        aux_req <= 2'h2;
        cyc(4);
        chk(main_gate, 2'h1);
        chk(aux_output, 2'h2);
        rd(`OFF_CTRL, 8'h09);
        @(posedge clk_sys);
        main_req <= 2'h0;
        aux_req <= 2'h0;
        cyc(4);
        chk({main_gate, aux_output}, 4'h0);
    endtask

    task automatic s_trip();
        @(posedge clk_sys);
        main_req <= 2'h1;
        cyc(4);
        @(posedge clk_sys);
        main_ilim <= 2'h1;
        cyc(DLY - 2);
        chk(main_gate, 2'h1);
        wait_trip();
        chk(alert_wire, 2'h2);
        @(posedge clk_sys);
        main_ilim <= 2'h0;
        cyc(4);
        chk(irq_wire, 1'b0);
        rd(`OFF_STAT_A, 8'h21);
        @(posedge clk_sys);
        main_req <= 2'h0;
        cyc(4);
        chk(alert_wire, 2'h3);
        chk(irq_wire, 1'b0);
        wr(`OFF_STAT_A, 8'h00);
        cyc(3);
        chk(irq_wire, 1'b0);
        wr(`OFF_STAT_A, 8'h21);
        cyc(3);
        chk(irq_wire, 1'b1);
    endtask

    task automatic s_both();
        @(posedge clk_sys);
        main_req <= 2'h1;
        aux_req <= 2'h1;
        cyc(4);
        @(posedge clk_sys);
        over_temp <= 2'h1;
        cyc(4);
        chk({main_gate[0], aux_output[0], alert_wire[0]}, 3'h0);
        @(posedge clk_sys);
        over_temp <= 2'h0;
        main_req <= 2'h0;
        cyc(5);
        chk(alert_wire, 2'h2);
        @(posedge clk_sys);
        aux_req <= 2'h0;
        cyc(4);
        chk(alert_wire, 2'h3);
        rd(`OFF_STAT_A, 8'h93);
        wr(`OFF_STAT_A, 8'hE3);
        cyc(3);
        chk(irq_wire, 1'b1);
        // Aux breaker on slot B
        @(posedge clk_sys);
        aux_req <= 2'h2;
        cyc(4);
        @(posedge clk_sys);
        aux_ilim <= 2'h2;
        cyc(DLY + 4);
        chk({aux_output, alert_wire}, 4'h1);
        @(posedge clk_sys);
        aux_ilim <= 2'h0;
        aux_req <= 2'h0;
        cyc(4);
        rd(`OFF_STAT_B, 8'h32);
        wr(`OFF_STAT_B, 8'hE3);
        cyc(3);
        chk(irq_wire, 1'b1);
    endtask

    task automatic s_mask();
        @(posedge clk_sys);
        sw_ctl <= 1'b1;
        wr(`OFF_CTRL, 8'h04);
        cyc(2);
        chk(main_gate, 2'h2);
        wr(`OFF_COMMON, 8'h08);
        @(posedge clk_sys);
        in_undervolt <= 2'h2;
        cyc(5);
        chk(main_gate, 2'h0);
        chk(irq_wire, 1'b1);
        @(posedge clk_sys);
        in_undervolt <= 2'h0;
        wr(`OFF_COMMON, 8'h00);
        cyc(3);
        chk(irq_wire, 1'b0);
        rd(`OFF_STAT_B, 8'h51);
        wr(`OFF_STAT_B, 8'hE3);
        cyc(3);
        chk(irq_wire, 1'b1);
        @(posedge clk_sys);
        sw_ctl <= 1'b0;
    endtask

    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, sw_ctl} = '0;
        {main_req, aux_req, main_ilim, aux_ilim} = '0;
        {in_undervolt, over_temp} = '0;
        general_input = 2'h2;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // Let the pin synchronisers fill before the first read
        cyc(3);
        s_regs();
        s_pins();
        s_trip();
        s_both();
        s_mask();
        final_report();
    end
endmodule // slot_power_fault_logic_tb_top
